// *** rtl/pma_phy_ctrl.sv ***
// Purpose: digital control of a 10/100 transceiver: nibble interface, management, negotiation
// Assumes: line_clk_i is the 50 MHz line reference; line logic supplies decoded symbols
// Notes:   straps are caught after reset release through the pin synchronisers
// Overview of operation
// - link_disable_n low keeps link pulses going and holds link state good
// - jabber_enable switches jabber on or off; it and heartbeat_enable reset to one
// - registers 20,21,23,24 read/write; 22 has read-only cable result over pll_select
// - transmit and receive clocks run at 25 MHz for 100M, 2.5 MHz for 10M
// - mac raises tx enable with nibbles; device samples them on its transmit clock
// - while receiving, device raises receive indication and drives nibbles on its clock
// - at 100M carrier sense follows non-idle symbols and drops on idle
// - at 10M carrier sense rises on confirmed preamble, drops on confirmed idle
// - at 100M receive valid rises on start pair, drops on end pair or idle
// - at 10M receive valid always equals carrier sense
// - transmit error input is ignored completely
// - with negotiation on, send fast pulse bursts and continue when partner bursts arrive
// - non-negotiating partner: normal pulses give 10M half, 100M idle gives 100M half
// - after exchange, run at the highest common speed and duplex
// - negotiation on: low speed strap drops 100M from the advertisement, low duplex strap drops full duplex
// - negotiation off: speed and duplex straps force the mode directly
// - pause bit 10 of advertisement_reg is sent in the advertisement
// - partner pause ability appears at bit 10 of partner_ability_reg
// - registers 20 to 24 reachable only while param_access_enable is one
`timescale 1ns/1ps
`include "pma_regs.svh"

module pma_phy_ctrl
	import pma_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        line_clk_i,
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	input  wire logic        autoneg_strap_i,
	input  wire logic        speed_strap_i,
	input  wire logic        duplex_strap_i,
	input  wire logic [4:0]  phy_addr_i,
	input  wire logic        flp_seen_i,
	input  wire logic        nlp_seen_i,
	input  wire logic        idle100_seen_i,
	input  wire logic        lp_word_valid_i,
	input  wire logic [15:0] lp_word_i,
	input  wire logic [7:0]  cable_length_result_i,
	output logic             flp_tx_o,
	output logic             link_good_o,
	output logic             speed_100_o,
	output logic             full_duplex_o,
	output logic             jabber_enable_o,
	output logic             heartbeat_enable_o,
	output logic [7:0]       pll_select_o,
	input  wire logic        tx_en_i,
	input  wire logic [3:0]  txd_i,
	input  wire logic        tx_er_i,
	input  wire logic [4:0]  line_sym_i,
	input  wire logic [3:0]  line_nib_i,
	input  wire logic        line_pre_ok_i,
	input  wire logic        line_idle_ok_i,
	output logic             tx_clk_o,
	output logic             rx_clk_o,
	output logic             crs_o,
	output logic             rx_dv_o,
	output logic [3:0]       rxd_o,
	output logic             line_tx_en_o,
	output logic [3:0]       line_txd_o
);

	localparam int NS = `PMA_NSYNC;
	localparam logic [3:0] TOP_100 = 4'(`PMA_LINE_HZ / (2 * `PMA_MII100_HZ) - 1);
	localparam logic [3:0] TOP_10  = 4'(`PMA_LINE_HZ / (2 * `PMA_MII10_HZ) - 1);

	pma_core_s c_r;
	pma_core_s c_nxt;
	pma_link_s l_r;
	pma_link_s l_nxt;

	logic [NS-1:0] pins;
	logic          mdc_rise;
	logic          din;
	logic          lpv_rise;
	logic          wr_fire;
	logic [15:0]   wd;
	logic [4:0]    ae;
	logic [3:0]    com;
	logic          mrise;
	logic          mfall;
	logic [3:0]    top;

	// pause and four abilities, pruned by straps
	function automatic logic [4:0] pma_adv_eff(input pma_core_s s);
		pma_adv_eff = {s.adv[4], s.adv[3] & s.sp_st & s.dx_st, s.adv[2] & s.sp_st,
			s.adv[1] & s.dx_st, s.adv[0]};
	endfunction : pma_adv_eff

	function automatic logic pma_is_param(input logic [4:0] a);
		pma_is_param = (a >= `PMA_REG_P1A) && (a <= `PMA_REG_LDB);
	endfunction : pma_is_param

	function automatic logic [15:0] pma_rd(input pma_core_s s, input logic [4:0] a);
		logic [4:0] e;
		e = pma_adv_eff(s);
		pma_rd = 16'h0000;
		if (pma_is_param(a) && !s.pae) begin
			pma_rd = 16'h0000;
		end else begin
			case (a)
				`PMA_REG_ADV:     pma_rd = {5'h00, e[4], 1'b0, e[3:0], `PMA_ADV_SEL};
				`PMA_REG_PARTNER: pma_rd = s.lp;
				`PMA_REG_MODE:    pma_rd = {15'h0000, s.pae};
				`PMA_REG_TENB:    pma_rd = {10'h000, s.ldn, 3'h0, s.hb, s.jab};
				`PMA_REG_P1A:     pma_rd = s.p1a;
				`PMA_REG_P1B:     pma_rd = s.p1b;
				`PMA_REG_CTPS:    pma_rd = {s.flt[21:14], s.pll};
				`PMA_REG_LDA:     pma_rd = s.tw1;
				`PMA_REG_LDB:     pma_rd = s.tw2;
				default:          pma_rd = 16'h0000;
			endcase
		end
	endfunction : pma_rd

	assign pins = {cable_length_result_i, phy_addr_i, duplex_strap_i, speed_strap_i,
		autoneg_strap_i, lp_word_valid_i, idle100_seen_i, nlp_seen_i, flp_seen_i, mdio_i, mdc_i};

	always_comb begin
		c_nxt = c_r;
		c_nxt.sy1 = pins;
		c_nxt.sy2 = c_r.sy1;
		c_nxt.sy3 = c_r.sy2;
		// accept a pin change only once two late stages agree
		for (int i = 0; i < NS; i++) begin
			if (c_r.sy2[i] == c_r.sy3[i]) begin
				c_nxt.flt[i] = c_r.sy3[i];
			end
		end
		mdc_rise = c_nxt.flt[0] & ~c_r.flt[0];
		din      = c_nxt.flt[1];
		lpv_rise = c_nxt.flt[5] & ~c_r.flt[5];
		wr_fire  = 1'b0;
		wd       = {c_r.sh[14:0], din};
		ae       = pma_adv_eff(c_r);
		com      = ae[3:0] & lp_word_i[8:5];

		if (mdc_rise) begin
			unique case (c_r.md)
				MD_IDLE: begin
					if (din) begin
						if (c_r.pre_cnt != `PMA_MDIO_PRE) begin
							c_nxt.pre_cnt = c_r.pre_cnt + 6'h01;
						end
					end else begin
						if (c_r.pre_cnt == `PMA_MDIO_PRE) begin
							c_nxt.md      = MD_HDR;
							c_nxt.bit_cnt = 5'h00;
						end
						c_nxt.pre_cnt = 6'h00;
					end
				end
				MD_HDR: begin
					c_nxt.sh      = wd;
					c_nxt.bit_cnt = c_r.bit_cnt + 5'h01;
					if (c_r.bit_cnt == `PMA_HDR_LAST) begin
						// only frames for our address are answered
						if (wd[12] && wd[9:5] == c_r.phy_addr &&
							(wd[11:10] == `PMA_OP_RD || wd[11:10] == `PMA_OP_WR)) begin
							c_nxt.md      = MD_TA;
							c_nxt.bit_cnt = 5'h00;
							c_nxt.op_rd   = (wd[11:10] == `PMA_OP_RD);
							c_nxt.reg_a   = wd[4:0];
							c_nxt.sh      = pma_rd(c_r, wd[4:0]);
						end else begin
							c_nxt.md = MD_IDLE;
						end
					end
				end
				MD_TA: begin
					if (c_r.bit_cnt == 5'h00) begin
						c_nxt.bit_cnt = 5'h01;
						if (c_r.op_rd) begin
							c_nxt.mdio_oe = 1'b1;
							c_nxt.mdio_do = 1'b0;
						end
					end else begin
						c_nxt.md      = MD_DATA;
						c_nxt.bit_cnt = 5'h00;
						if (c_r.op_rd) begin
							c_nxt.mdio_do = c_r.sh[15];
							c_nxt.sh      = {c_r.sh[14:0], 1'b0};
						end
					end
				end
				MD_DATA: begin
					c_nxt.bit_cnt = c_r.bit_cnt + 5'h01;
					if (c_r.op_rd) begin
						c_nxt.mdio_do = c_r.sh[15];
						c_nxt.sh      = {c_r.sh[14:0], 1'b0};
					end else begin
						c_nxt.sh = wd;
					end
					if (c_r.bit_cnt == `PMA_DATA_LAST) begin
						c_nxt.md      = MD_IDLE;
						c_nxt.mdio_oe = 1'b0;
						c_nxt.bit_cnt = 5'h00;
						wr_fire       = ~c_r.op_rd;
					end
				end
				default: begin
					c_nxt.md = MD_IDLE;
				end
			endcase
		end

		if (wr_fire) begin
			case (c_r.reg_a)
				`PMA_REG_ADV: begin
					c_nxt.adv = {wd[`PMA_ADV_PAUSE], wd[8:5]};
				end
				`PMA_REG_MODE: begin
					c_nxt.pae = wd[`PMA_MODE_PAE];
				end
				`PMA_REG_TENB: begin
					c_nxt.ldn = wd[`PMA_TENB_LDN];
					c_nxt.hb  = wd[`PMA_TENB_HB];
					c_nxt.jab = wd[`PMA_TENB_JAB];
				end
				`PMA_REG_P1A: if (c_r.pae) c_nxt.p1a = wd;
				`PMA_REG_P1B: if (c_r.pae) c_nxt.p1b = wd;
				`PMA_REG_CTPS: if (c_r.pae) c_nxt.pll = wd[7:0];
				`PMA_REG_LDA: if (c_r.pae) c_nxt.tw1 = wd;
				`PMA_REG_LDB: if (c_r.pae) c_nxt.tw2 = wd;
				default: begin
				end
			endcase
		end

		unique case (c_r.an)
			AN_STRAP: begin
				if (c_r.st_cnt != `PMA_STRAP_WAIT) begin
					c_nxt.st_cnt = c_r.st_cnt + 2'h1;
				end else begin
					// filtered straps only settle on this edge, so take the next value
					c_nxt.an_en    = c_nxt.flt[6];
					c_nxt.sp_st    = c_nxt.flt[7];
					c_nxt.dx_st    = c_nxt.flt[8];
					c_nxt.phy_addr = c_nxt.flt[13:9];
					if (c_nxt.flt[6]) begin
						c_nxt.an     = AN_FLP;
						c_nxt.flp_tx = 1'b1;
					end else begin
						c_nxt.spd100 = c_nxt.flt[7];
						c_nxt.fdx    = c_nxt.flt[8];
						c_nxt.an     = AN_LINK;
					end
				end
			end
			AN_FLP: begin
				if (c_r.flt[2]) begin
					c_nxt.an = AN_EXCH;
				end else if (c_r.flt[3] || c_r.flt[4]) begin
					c_nxt.spd100 = ~c_r.flt[3];
					c_nxt.fdx    = 1'b0;
					c_nxt.flp_tx = 1'b0;
					c_nxt.an     = AN_LINK;
				end
			end
			AN_EXCH: begin
				if (lpv_rise) begin
					c_nxt.lp     = lp_word_i;
					c_nxt.spd100 = com[3] | com[2];
					c_nxt.fdx    = com[3] | (~com[2] & com[1]);
					c_nxt.flp_tx = 1'b0;
					c_nxt.an     = AN_LINK;
				end
			end
			AN_LINK: begin
			end
			default: begin
				c_nxt.an = AN_STRAP;
			end
		endcase
		// disabled link check keeps the link good
		c_nxt.link_good = (c_nxt.an == AN_LINK) | ~c_nxt.ldn;

		if (rst_i) begin
			c_nxt     = '0;
			c_nxt.md  = MD_IDLE;
			c_nxt.an  = AN_STRAP;
			c_nxt.adv = `PMA_ADV_RST;
			c_nxt.ldn = 1'b1;
			c_nxt.hb  = 1'b1;
			c_nxt.jab = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		c_r <= c_nxt;
	end

	assign mdio_o             = c_r.mdio_do;
	assign mdio_oe_o          = c_r.mdio_oe;
	assign flp_tx_o           = c_r.flp_tx;
	assign link_good_o        = c_r.link_good;
	assign speed_100_o        = c_r.spd100;
	assign full_duplex_o      = c_r.fdx;
	assign jabber_enable_o    = c_r.jab;
	assign heartbeat_enable_o = c_r.hb;
	assign pll_select_o       = c_r.pll;

	// line domain; speed arrives as a slow level, so two flops suffice
	always_comb begin
		l_nxt     = l_r;
		l_nxt.ss1 = c_r.spd100;
		l_nxt.ss2 = l_r.ss1;
		top       = l_r.ss2 ? TOP_100 : TOP_10;
		mrise     = 1'b0;
		mfall     = 1'b0;
		if (l_r.cnt >= top) begin
			l_nxt.cnt  = 4'h0;
			l_nxt.mclk = ~l_r.mclk;
			mrise      = ~l_r.mclk;
			mfall      = l_r.mclk;
		end else begin
			l_nxt.cnt = l_r.cnt + 4'h1;
		end
		// transmit error never reaches this path
		if (mrise) begin
			l_nxt.txen = tx_en_i;
			l_nxt.txd  = tx_en_i ? txd_i : 4'h0;
		end
		if (l_r.ss2) begin
			if (mfall) begin
				l_nxt.crs = (line_sym_i != `PMA_SYM_IDLE);
				if (l_r.prev == `PMA_SYM_J && line_sym_i == `PMA_SYM_K) begin
					l_nxt.rxdv = 1'b1;
				end else if ((l_r.prev == `PMA_SYM_T && line_sym_i == `PMA_SYM_R) ||
					line_sym_i == `PMA_SYM_IDLE) begin
					l_nxt.rxdv = 1'b0;
				end
				l_nxt.rxd  = l_nxt.rxdv ? line_nib_i : 4'h0;
				l_nxt.prev = line_sym_i;
			end
		end else begin
			if (line_pre_ok_i) begin
				l_nxt.crs = 1'b1;
			end else if (line_idle_ok_i) begin
				l_nxt.crs = 1'b0;
			end
			l_nxt.rxdv = l_nxt.crs;
			if (mfall) begin
				l_nxt.rxd = l_nxt.crs ? line_nib_i : 4'h0;
			end
		end
		if (l_r.lr2) begin
			l_nxt = '0;
		end
		l_nxt.lr1 = rst_i;
		l_nxt.lr2 = l_r.lr1;
	end

	always_ff @(posedge line_clk_i) begin
		l_r <= l_nxt;
	end

	assign tx_clk_o     = l_r.mclk;
	assign rx_clk_o     = l_r.mclk;
	assign crs_o        = l_r.crs;
	assign rx_dv_o      = l_r.rxdv;
	assign rxd_o        = l_r.rxd;
	assign line_tx_en_o = l_r.txen;
	assign line_txd_o   = l_r.txd;

	ld_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) !c_r.ldn |-> link_good_o)
		else $error("link not held good with link check disabled");
	tenb_rst_a: assert property (@(posedge clk_i) $fell(rst_i) |-> jabber_enable_o && heartbeat_enable_o && c_r.ldn)
		else $error("10M config reset values wrong");
	par_lock_a: assert property (@(posedge clk_i) disable iff (rst_i) (wr_fire && pma_is_param(c_r.reg_a) && !c_r.pae) |=> $stable(c_r.p1a) && $stable(c_r.tw2) && $stable(c_r.pll))
		else $error("parameter register written while locked");
	force_mode_a: assert property (@(posedge clk_i) disable iff (rst_i) (c_r.an == AN_LINK && !c_r.an_en) |-> speed_100_o == c_r.sp_st && full_duplex_o == c_r.dx_st)
		else $error("forced mode does not follow straps");
	flp_send_a: assert property (@(posedge clk_i) disable iff (rst_i) (c_r.an == AN_FLP) |-> flp_tx_o and (c_r.flt[2] |=> c_r.an == AN_EXCH))
		else $error("pulse bursts not sent or partner bursts ignored");
	pd_nlp_a: assert property (@(posedge clk_i) disable iff (rst_i) (c_r.an == AN_FLP && !c_r.flt[2] && c_r.flt[3]) |=> c_r.an == AN_LINK && !speed_100_o && !full_duplex_o)
		else $error("normal pulses did not give 10M half duplex");
	hcd_pick_a: assert property (@(posedge clk_i) disable iff (rst_i) (c_r.an == AN_EXCH && lpv_rise) |=> speed_100_o == $past(|com[3:2]) && c_r.lp[`PMA_ADV_PAUSE] == $past(lp_word_i[`PMA_ADV_PAUSE]))
		else $error("resolved mode or partner pause wrong");
	adv_mask_a: assert property (@(posedge clk_i) disable iff (rst_i) (c_r.an != AN_STRAP && !c_r.sp_st) |-> ae[3:2] == 2'h0)
		else $error("100M advertised with speed strap low");
	dv_eq_a: assert property (@(posedge line_clk_i) disable iff (l_r.lr2) (!l_r.ss2 && !$past(l_r.ss2)) |-> rx_dv_o == crs_o)
		else $error("10M receive valid differs from carrier sense");
	idle_drop_a: assert property (@(posedge line_clk_i) disable iff (l_r.lr2) (l_r.ss2 && mfall && line_sym_i == `PMA_SYM_IDLE) |=> !crs_o && !rx_dv_o)
		else $error("idle did not drop carrier or valid");
	jk_start_a: assert property (@(posedge line_clk_i) disable iff (l_r.lr2) (l_r.ss2 && mfall && l_r.prev == `PMA_SYM_J && line_sym_i == `PMA_SYM_K) |=> rx_dv_o)
		else $error("start pair did not raise valid");
	tx_take_a: assert property (@(posedge line_clk_i) disable iff (l_r.lr2) (mrise && tx_en_i) |=> line_tx_en_o && line_txd_o == $past(txd_i))
		else $error("transmit nibble not taken on clock edge");
	crs10_a: assert property (@(posedge line_clk_i) disable iff (l_r.lr2) (!l_r.ss2 && line_pre_ok_i) |=> crs_o)
		else $error("10M preamble did not raise carrier");
	fast_clk_a: assert property (@(posedge line_clk_i) disable iff (l_r.lr2) (l_r.ss2 && $past(l_r.ss2) && $past(l_r.ss2, 2)) |-> tx_clk_o != $past(tx_clk_o))
		else $error("100M interface clock not at half line rate");

	an_exch_c: cover property (@(posedge clk_i) disable iff (rst_i) c_r.an == AN_EXCH ##1 c_r.an == AN_LINK);
	mdio_rd_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(mdio_oe_o));
	dv_100_c: cover property (@(posedge line_clk_i) disable iff (l_r.lr2) l_r.ss2 && $rose(rx_dv_o));

endmodule : pma_phy_ctrl

// *** inc/pma_regs.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the phy control block
// Assumes: management register addresses are 5-bit indices
// Notes:   definitions only
`ifndef PMA_REGS_SVH
`define PMA_REGS_SVH

`define PMA_REG_ADV      5'h04
`define PMA_REG_PARTNER  5'h05
`define PMA_REG_MODE     5'h11
`define PMA_REG_TENB     5'h13
`define PMA_REG_P1A      5'h14
`define PMA_REG_P1B      5'h15
`define PMA_REG_CTPS     5'h16
`define PMA_REG_LDA      5'h17
`define PMA_REG_LDB      5'h18

`define PMA_ADV_PAUSE    10
`define PMA_ADV_SEL      5'h01
`define PMA_ADV_RST      5'h0F
`define PMA_TENB_LDN     5
`define PMA_TENB_HB      1
`define PMA_TENB_JAB     0
`define PMA_MODE_PAE     0

`define PMA_MDIO_PRE     6'h20
`define PMA_OP_RD        2'h2
`define PMA_OP_WR        2'h1
`define PMA_HDR_LAST     5'h0C
`define PMA_DATA_LAST    5'h0F
`define PMA_STRAP_WAIT   2'h3

`define PMA_SYM_IDLE     5'h1F
`define PMA_SYM_J        5'h18
`define PMA_SYM_K        5'h11
`define PMA_SYM_T        5'h0D
`define PMA_SYM_R        5'h07

`define PMA_LINE_HZ      50000000
`define PMA_MII100_HZ    25000000
`define PMA_MII10_HZ     2500000
`define PMA_NSYNC        22

`endif

// *** inc/pma_pkg.sv ***
// Purpose: types of the phy control block
// Assumes: pma_regs.svh supplies the sync vector width
// Notes:   state of each clock domain is one packed struct
`include "pma_regs.svh"

package pma_pkg;

	typedef enum logic [3:0] {
		MD_IDLE = 4'b0001,
		MD_HDR  = 4'b0010,
		MD_TA   = 4'b0100,
		MD_DATA = 4'b1000
	} pma_md_e;

	typedef enum logic [3:0] {
		AN_STRAP = 4'b0001,
		AN_FLP   = 4'b0010,
		AN_EXCH  = 4'b0100,
		AN_LINK  = 4'b1000
	} pma_an_e;

	typedef struct packed {
		logic [`PMA_NSYNC-1:0] sy1;
		logic [`PMA_NSYNC-1:0] sy2;
		logic [`PMA_NSYNC-1:0] sy3;
		logic [`PMA_NSYNC-1:0] flt;
		pma_md_e               md;
		logic [5:0]            pre_cnt;
		logic [4:0]            bit_cnt;
		logic [15:0]           sh;
		logic                  op_rd;
		logic [4:0]            reg_a;
		logic                  mdio_oe;
		logic                  mdio_do;
		pma_an_e               an;
		logic [1:0]            st_cnt;
		logic                  an_en;
		logic                  sp_st;
		logic                  dx_st;
		logic [4:0]            phy_addr;
		logic [4:0]            adv;
		logic [15:0]           lp;
		logic                  pae;
		logic                  ldn;
		logic                  hb;
		logic                  jab;
		logic [15:0]           p1a;
		logic [15:0]           p1b;
		logic [15:0]           tw1;
		logic [15:0]           tw2;
		logic [7:0]            pll;
		logic                  spd100;
		logic                  fdx;
		logic                  flp_tx;
		logic                  link_good;
	} pma_core_s;

	typedef struct packed {
		logic       lr1;
		logic       lr2;
		logic       ss1;
		logic       ss2;
		logic [3:0] cnt;
		logic       mclk;
		logic       crs;
		logic       rxdv;
		logic [3:0] rxd;
		logic [4:0] prev;
		logic [3:0] txd;
		logic       txen;
	} pma_link_s;

endpackage : pma_pkg

// *** verif/pma_mac_model.sv ***
// Purpose: mac side model: software management clock master and nibble transmitter
// Assumes: core clock paces mdc, 16 core cycles per management bit
// Notes:   model lets go of mdio for read turnaround and data
`timescale 1ns/1ps
module pma_mac_model (
	input  wire logic       clk_i,
	input  wire logic       tx_clk_i,
	input  wire logic       mdio_i,
	output logic            mdc_o,
	output logic            mdio_o,
	output logic            mdio_oe_o,
	output logic            tx_en_o,
	output logic [3:0]      txd_o
);
	initial begin
		{mdc_o, mdio_o, mdio_oe_o, tx_en_o, txd_o} = 8'h00;
	end

	// mdc is made in software; data changes only while mdc is low
	task automatic mbit(input logic v, input logic drv, output logic s);
		@(negedge clk_i);
		mdc_o = 1'b0;
		mdio_o = v;
		mdio_oe_o = drv;
		repeat (8) @(negedge clk_i);
		s = mdio_i;
		mdc_o = 1'b1;
		repeat (7) @(negedge clk_i);
	endtask : mbit

	task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] q);
		logic [13:0] hdr;
		logic        s;
		hdr = {2'b01, rd ? 2'b10 : 2'b01, pa, ra};
		for (int i = 0; i < 32; i++)
			mbit(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--)
			mbit(hdr[i], 1'b1, s);
		mbit(1'b1, !rd, s);
		mbit(1'b0, !rd, s);
		for (int i = 15; i >= 0; i--) begin
			mbit(wd[i], !rd, s);
			q[i] = s;
		end
		@(negedge clk_i);
		mdc_o = 1'b0;
		mdio_oe_o = 1'b0;
		repeat (16) @(negedge clk_i);
	endtask : frame

	task automatic tx_step(input logic en, input logic [3:0] nib);
		@(posedge tx_clk_i);
		tx_en_o <= en;
		txd_o <= nib;
	endtask : tx_step
endmodule : pma_mac_model

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the phy control block
// Assumes: line clock 80 ns, core clock 25 ns, mdio pulled up on the board
// Notes:   expected values are worked out from straps and register contents
`timescale 1ns/1ps
`include "pma_regs.svh"
module tb_top;
	localparam logic [4:0] PA = 5'h05;
	logic        clk_i, rst_i, line_clk_i;
	logic        mdc, mac_do, mac_oe, dut_do, dut_oe;
	wire         mdio_line;
	logic        an, sp, dx, flp, nlp, idle, lpv;
	logic [15:0] lpw, q, lp, d;
	logic [7:0]  cable, pll;
	logic        flp_tx, link_good, spd, fdx, jab, hb, dv_m;
	logic        tx_en, tx_er, pre_ok, idle_ok, tx_clk, rx_clk, crs, rx_dv, ltx_en;
	logic [3:0]  txd, nib, rxd, ltxd, adv, cm;
	logic [4:0]  sym, prev;
	logic [4:0]  tv [10];
	logic [4:0]  sq [10];
	logic [4:0]  prm [4];
	int          n_errors, samples_checked;

	// a released line floats high through the pull-up
	assign mdio_line = dut_oe ? dut_do : (mac_oe ? mac_do : 1'b1);

	always #12.5 clk_i = ~clk_i;
	always #40 line_clk_i = ~line_clk_i;

	pma_phy_ctrl pma_phy_ctrl_inst (
		.clk_i(clk_i), .rst_i(rst_i), .line_clk_i(line_clk_i),
		.mdc_i(mdc), .mdio_i(mdio_line), .mdio_o(dut_do), .mdio_oe_o(dut_oe),
		.autoneg_strap_i(an), .speed_strap_i(sp), .duplex_strap_i(dx),
		.phy_addr_i(PA), .flp_seen_i(flp), .nlp_seen_i(nlp), .idle100_seen_i(idle),
		.lp_word_valid_i(lpv), .lp_word_i(lpw), .cable_length_result_i(cable),
		.flp_tx_o(flp_tx), .link_good_o(link_good), .speed_100_o(spd),
		.full_duplex_o(fdx), .jabber_enable_o(jab), .heartbeat_enable_o(hb),
		.pll_select_o(pll), .tx_en_i(tx_en), .txd_i(txd), .tx_er_i(tx_er),
		.line_sym_i(sym), .line_nib_i(nib), .line_pre_ok_i(pre_ok),
		.line_idle_ok_i(idle_ok), .tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .crs_o(crs),
		.rx_dv_o(rx_dv), .rxd_o(rxd), .line_tx_en_o(ltx_en), .line_txd_o(ltxd)
	);

	pma_mac_model pma_mac_model_inst (
		.clk_i(clk_i), .tx_clk_i(tx_clk), .mdio_i(mdio_line), .mdc_o(mdc),
		.mdio_o(mac_do), .mdio_oe_o(mac_oe), .tx_en_o(tx_en), .txd_o(txd)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
		logic [15:0] r;
		pma_mac_model_inst.frame(1'b0, PA, ra, wd, r);
	endtask : wr

	task automatic rd(input logic [4:0] ra, output logic [15:0] r);
		pma_mac_model_inst.frame(1'b1, PA, ra, 16'h0000, r);
	endtask : rd

	// straps are held across reset, the block catches them after release
	task automatic reset_dut(input logic a, input logic s, input logic x);
		@(negedge clk_i);
		rst_i = 1'b1;
		{an, sp, dx} = {a, s, x};
		{flp, nlp, idle, lpv} = 4'h0;
		repeat (20) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (12) @(negedge clk_i);
	endtask : reset_dut

	task automatic period(input int exp);
		realtime t0;
		@(posedge tx_clk);
		t0 = $realtime;
		chk(16'(rx_clk), 16'h0001);
		@(posedge tx_clk);
		chk(16'(int'($realtime - t0)), 16'(exp));
	endtask : period

	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	initial begin
		{clk_i, line_clk_i, rst_i, an, sp, dx, flp, nlp, idle, lpv} = 10'h080;
		{tx_er, pre_ok, idle_ok, nib, lpw, cable} = 31'h0;
		sym = `PMA_SYM_IDLE;
		n_errors = 0;
		samples_checked = 0;
		prm = '{`PMA_REG_P1A, `PMA_REG_P1B, `PMA_REG_LDA, `PMA_REG_LDB};
		sq = '{`PMA_SYM_IDLE, `PMA_SYM_IDLE, `PMA_SYM_J, `PMA_SYM_K, 5'h1E, 5'h1E,
			5'h1E, `PMA_SYM_T, `PMA_SYM_R, `PMA_SYM_IDLE};
		void'($urandom(65850));
		cable = 8'($urandom);
		for (int m = 0; m < 4; m++) begin
			reset_dut(1'b0, m[1], m[0]);
			chk(16'({spd, fdx}), 16'(m));
		end
		rd(`PMA_REG_TENB, q);
		chk(q, 16'h0023);
		chk(16'({jab, hb}), 16'h0003);
		wr(`PMA_REG_TENB, 16'hFFDC);
		rd(`PMA_REG_TENB, q);
		chk(q, 16'h0000);
		chk(16'({jab, hb}), 16'h0000);
		wr(`PMA_REG_TENB, 16'h0021);
		chk(16'({jab, hb}), 16'h0002);
		wr(`PMA_REG_P1A, 16'hA5A5);
		rd(`PMA_REG_P1A, q);
		chk(q, 16'h0000);
		wr(`PMA_REG_MODE, 16'hFFFF);
		rd(`PMA_REG_MODE, q);
		chk(q, 16'h0001);
		foreach (prm[i]) begin
			d = 16'($urandom);
			wr(prm[i], d);
			rd(prm[i], q);
			chk(q, d);
		end
		d = 16'($urandom);
		wr(`PMA_REG_CTPS, d);
		rd(`PMA_REG_CTPS, q);
		chk(q, {cable, d[7:0]});
		chk(16'(pll), 16'(d[7:0]));
		wr(`PMA_REG_MODE, 16'h0000);
		rd(`PMA_REG_LDB, q);
		chk(q, 16'h0000);
		pma_mac_model_inst.frame(1'b1, PA ^ 5'h01, `PMA_REG_TENB, 16'h0000, q);
		chk(q, 16'hFFFF);
		period(160);
		for (int i = 0; i < 10; i++) begin
			tv[i] = (i > 0 && i < 9) ? {1'b1, 4'($urandom)} : 5'h00;
			tx_er = 1'($urandom);
			pma_mac_model_inst.tx_step(tv[i][4], tv[i][3:0]);
			if (i > 0) begin
				@(negedge tx_clk);
				#1;
				chk(16'({ltx_en, ltxd}), 16'(tv[i-1]));
			end
		end
		prev = `PMA_SYM_IDLE;
		dv_m = 1'b0;
		for (int i = 0; i < 10; i++) begin
			@(posedge tx_clk);
			@(negedge line_clk_i);
			sym = sq[i];
			nib = 4'($urandom);
			@(negedge tx_clk);
			@(negedge line_clk_i);
			if (prev == `PMA_SYM_J && sym == `PMA_SYM_K)
				dv_m = 1'b1;
			if ((prev == `PMA_SYM_T && sym == `PMA_SYM_R) || sym == `PMA_SYM_IDLE)
				dv_m = 1'b0;
			prev = sym;
			chk(16'({crs, rx_dv}), 16'({sym != `PMA_SYM_IDLE, dv_m}));
			if (i > 3 && i < 7)
				chk(16'(rxd), 16'(nib));
		end
		for (int m = 0; m < 4; m++) begin
			reset_dut(1'b1, m[1], m[0]);
			adv = {m[1] & m[0], m[1], m[0], 1'b1};
			chk(16'(flp_tx), 16'h0001);
			wr(`PMA_REG_ADV, 16'h05E1);
			rd(`PMA_REG_ADV, q);
			chk(q & 16'h07E0, {6'h01, 1'b0, adv, 5'h00});
			lp = {5'h00, 1'($urandom), 1'b0, 4'($urandom), 5'h01};
			lpw = lp;
			repeat (6) @(negedge clk_i);
			flp = 1'b1;
			repeat (10) @(negedge clk_i);
			lpv = 1'b1;
			repeat (20) @(negedge clk_i);
			cm = adv & lp[8:5];
			d = cm[3] ? 16'h000E : cm[2] ? 16'h000A : cm[1] ? 16'h0006 : 16'h0002;
			chk(16'({spd, fdx, link_good, flp_tx}), d);
			rd(`PMA_REG_PARTNER, q);
			chk(16'(q[10]), 16'(lp[10]));
		end
		for (int k = 0; k < 2; k++) begin
			reset_dut(1'b1, 1'b1, 1'b1);
			{idle, nlp} = 2'(k + 1);
			repeat (12) @(negedge clk_i);
			chk(16'({spd, fdx}), 16'({k[0], 1'b0}));
		end
		reset_dut(1'b1, 1'b1, 1'b1);
		wr(`PMA_REG_TENB, 16'h0003);
		chk(16'({link_good, flp_tx}), 16'h0003);
		reset_dut(1'b0, 1'b0, 1'b0);
		period(1600);
		@(negedge line_clk_i);
		pre_ok = 1'b1;
		@(negedge line_clk_i);
		pre_ok = 1'b0;
		repeat (3) @(negedge line_clk_i);
		chk(16'({crs, rx_dv}), 16'h0003);
		idle_ok = 1'b1;
		@(negedge line_clk_i);
		idle_ok = 1'b0;
		repeat (3) @(negedge line_clk_i);
		chk(16'({crs, rx_dv}), 16'h0000);
		close_out();
	end

	// about 34 management frames of 26 us each plus margin
	initial begin
		#2000000;
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		close_out();
	end
endmodule : tb_top
